// *** hw/return_stack_control.sv ***
// Return address stack, stack control register and fast shadow stack.
// Assumes the sequencer, core reset and Wishbone master share mclk_in.
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps

module return_stack_control
   import return_stack_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic        core_reset_in,
   input  wire seq_req_t    seq_req_in,
   output seq_ans_t         seq_ans_out,
   output logic             fault_reset_out,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [4:0]  level_reg;
   logic [4:0]  level_next;
   logic        full_reg;
   logic        full_next;
   logic        under_reg;
   logic        under_next;
   logic        option_reg;
   logic [20:0] mem [1:31];
   logic [20:0] top_value;
   shadow_t     shadow_reg;
   bus_state_t  bus_state_reg;
   logic        bus_go;
   logic        bus_wr;
   logic        bus_rd;
   logic        push_go;
   logic        pop_go;
   logic        at_top;
   logic        full_set;
   logic        under_set;
   logic        fault;
   logic        ctl_wr;
   logic [7:0]  rd_byte;

   function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
      return adr == off;
   endfunction

   // ---------------------------------------------------------------
   // Request decode
   // ---------------------------------------------------------------
   // Register access only in the low byte lane
   assign bus_go    = wb_cyc_in && wb_stb_in && (bus_state_reg == BUS_IDLE);
   assign bus_wr    = bus_go && wb_we_in && wb_sel_in[0];
   assign bus_rd    = bus_go && !wb_we_in;
   assign ctl_wr    = bus_wr && hit(wb_adr_in, OFF_CONTROL);
   // Push wins over a simultaneous pop; the sequencer never issues both
   assign push_go   = seq_req_in.push;
   assign pop_go    = seq_req_in.pop && !seq_req_in.push;
   assign at_top    = level_reg == LEVEL_MAX;
   assign full_set  = push_go && (level_reg >= LEVEL_LAST);
   assign under_set = pop_go && (level_reg == 5'h00);
   assign fault     = option_reg && (full_set || under_set);
   // Level zero has no storage and reads as zero
   assign top_value = (level_reg == 5'h00) ? 21'h000000 : mem[level_reg];

   // ---------------------------------------------------------------
   // Stack level and flags
   // ---------------------------------------------------------------
   always_comb begin
      level_next = level_reg;
      if (ctl_wr) begin
         level_next = wb_dat_in[4:0];
      end
      if (push_go) begin
         // With the option clear, a push at the top keeps the level even against a software write
         level_next = at_top ? LEVEL_MAX : level_reg + 5'h01;
      end else if (pop_go && level_reg != 5'h00) begin
         level_next = level_reg - 5'h01;
      end
      if (fault || core_reset_in) begin
         level_next = 5'h00;
      end
   end

   // Software may only clear; the hardware set is applied last so it wins
   always_comb begin
      full_next  = full_reg;
      under_next = under_reg;
      if (ctl_wr && !wb_dat_in[FULL_BIT]) begin
         full_next = 1'b0;
      end
      if (ctl_wr && !wb_dat_in[UNDER_BIT]) begin
         under_next = 1'b0;
      end
      if (full_set) begin
         full_next = 1'b1;
      end
      if (under_set) begin
         under_next = 1'b1;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         level_reg <= CONTROL_RESET[4:0];
         full_reg  <= CONTROL_RESET[FULL_BIT];
         under_reg <= CONTROL_RESET[UNDER_BIT];
      end else begin
         level_reg <= level_next;
         full_reg  <= full_next;
         under_reg <= under_next;
      end
   end

   // Stack-fault reset option, on by default
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         option_reg <= OPTION_RESET;
      end else if (bus_wr && hit(wb_adr_in, OFF_CONFIG)) begin
         option_reg <= wb_dat_in[OPTION_BIT];
      end
   end

   // Device reset request, registered on the same edge that sets the flag
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fault_reset_out <= 1'b0;
      end else begin
         fault_reset_out <= fault;
      end
   end

   // ---------------------------------------------------------------
   // Return store
   // ---------------------------------------------------------------
   // No reset on the array: contents are undefined until pushed
   always_ff @(posedge mclk_in) begin
      if (push_go && !at_top) begin
         mem[level_reg + 5'h01] <= seq_req_in.push_value;
      end else if (bus_wr && level_reg != 5'h00) begin
         if (hit(wb_adr_in, OFF_TOP_LOW)) begin
            mem[level_reg][7:0] <= wb_dat_in[7:0];
         end else if (hit(wb_adr_in, OFF_TOP_HIGH)) begin
            mem[level_reg][15:8] <= wb_dat_in[7:0];
         end else if (hit(wb_adr_in, OFF_TOP_UPPER)) begin
            mem[level_reg][20:16] <= wb_dat_in[4:0];
         end
      end
   end

   // Underflow answers zero and touches nothing else
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seq_ans_out.pop_valid <= 1'b0;
         seq_ans_out.pop_value <= 21'h000000;
      end else begin
         seq_ans_out.pop_valid <= pop_go;
         if (pop_go) begin
            seq_ans_out.pop_value <= top_value;
         end
      end
   end

   // ---------------------------------------------------------------
   // Fast shadow stack
   // ---------------------------------------------------------------
   // One level only: a nested save overwrites the earlier one
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         shadow_reg <= '0;
      end else if (seq_req_in.fast_save) begin
         shadow_reg <= seq_req_in.live;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seq_ans_out.restore_valid <= 1'b0;
         seq_ans_out.restore       <= '0;
      end else begin
         seq_ans_out.restore_valid <= seq_req_in.fast_restore;
         if (seq_req_in.fast_restore) begin
            seq_ans_out.restore <= shadow_reg;
         end
      end
   end

   // ---------------------------------------------------------------
   // Wishbone slave
   // ---------------------------------------------------------------
   always_comb begin
      rd_byte = 8'h00;
      if (hit(wb_adr_in, OFF_CONTROL)) begin
         rd_byte = {full_reg, under_reg, 1'b0, level_reg};
      end else if (hit(wb_adr_in, OFF_TOP_LOW)) begin
         rd_byte = top_value[7:0];
      end else if (hit(wb_adr_in, OFF_TOP_HIGH)) begin
         rd_byte = top_value[15:8];
      end else if (hit(wb_adr_in, OFF_TOP_UPPER)) begin
         rd_byte = {3'h0, top_value[20:16]};
      end else if (hit(wb_adr_in, OFF_CONFIG)) begin
         rd_byte = {7'h00, option_reg};
      end
   end

   // Every access is answered after one cycle; unmapped reads give zero
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_state_reg <= BUS_IDLE;
         wb_ack_out    <= 1'b0;
         wb_dat_out    <= 32'h00000000;
      end else begin
         case (bus_state_reg)
            BUS_IDLE: begin
               if (wb_cyc_in && wb_stb_in) begin
                  bus_state_reg <= BUS_ACK;
                  wb_ack_out    <= 1'b1;
                  wb_dat_out    <= bus_rd ? {24'h000000, rd_byte} : 32'h00000000;
               end
            end
            BUS_ACK: begin
               bus_state_reg <= BUS_IDLE;
               wb_ack_out    <= 1'b0;
            end
            default: begin
               bus_state_reg <= BUS_IDLE;
               wb_ack_out    <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   logic quiet;
   assign quiet = !core_reset_in && !fault;

   sequence s_save;
      seq_req_in.fast_save;
   endsequence

   sequence s_restore;
      !seq_req_in.fast_save && seq_req_in.fast_restore;
   endsequence

   // Without a software write or a reset the level only steps by one
   property p_level_range;
      !ctl_wr && quiet
         |=> level_reg == $past(level_reg)
             || level_reg == $past(level_reg) + 5'h01
             || level_reg == $past(level_reg) - 5'h01;
   endproperty
   a_level_range: assert property (p_level_range)
      else $error("stack level moved by more than one step");

   property p_push_store;
      push_go && level_reg < LEVEL_LAST && !core_reset_in
         |=> level_reg == $past(level_reg) + 5'h01
             && top_value == $past(seq_req_in.push_value);
   endproperty
   a_push_store: assert property (p_push_store)
      else $error("push did not raise level and store value");

   property p_pop;
      pop_go && level_reg != 5'h00 && !core_reset_in
         |=> level_reg == $past(level_reg) - 5'h01
             && seq_ans_out.pop_valid
             && seq_ans_out.pop_value == $past(top_value);
   endproperty
   a_pop: assert property (p_pop)
      else $error("pop did not return top and lower level");

   property p_core_reset;
      core_reset_in |=> level_reg == 5'h00;
   endproperty
   a_core_reset: assert property (p_core_reset)
      else $error("reset left stack level nonzero");

   property p_sw_level;
      ctl_wr && !seq_req_in.push && !seq_req_in.pop && !core_reset_in
         |=> level_reg == $past(wb_dat_in[4:0]);
   endproperty
   a_sw_level: assert property (p_sw_level)
      else $error("software level write lost");

   property p_full_set;
      push_go && level_reg == LEVEL_LAST |=> full_reg;
   endproperty
   a_full_set: assert property (p_full_set)
      else $error("full flag not set on last push");

   property p_flag_hold;
      (full_reg && !(ctl_wr && !wb_dat_in[FULL_BIT])) || full_set |=> full_reg;
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("full flag cleared without software");

   property p_fault_reset;
      option_reg && push_go && level_reg == LEVEL_LAST
         |=> fault_reset_out && full_reg && level_reg == 5'h00;
   endproperty
   a_fault_reset: assert property (p_fault_reset)
      else $error("overflow with option set did not reset");

   property p_hold_top;
      !option_reg && push_go && at_top && !core_reset_in
         |=> level_reg == LEVEL_MAX && top_value == $past(top_value);
   endproperty
   a_hold_top: assert property (p_hold_top)
      else $error("push at full stack changed the stack");

   property p_underflow;
      under_set |=> under_reg && level_reg == 5'h00 && seq_ans_out.pop_value == 21'h000000;
   endproperty
   a_underflow: assert property (p_underflow)
      else $error("underflow handling wrong");

   property p_no_reset;
      !option_reg && (full_set || under_set) |=> !fault_reset_out;
   endproperty
   a_no_reset: assert property (p_no_reset)
      else $error("reset raised with option cleared");

   property p_ctl_read;
      bus_rd && hit(wb_adr_in, OFF_CONTROL)
         |=> wb_ack_out && wb_dat_out[5] == 1'b0
             && wb_dat_out[7:6] == $past({full_reg, under_reg});
   endproperty
   a_ctl_read: assert property (p_ctl_read)
      else $error("control register read wrong");

   property p_fast;
      s_save ##1 s_restore
         |=> seq_ans_out.restore_valid && seq_ans_out.restore == $past(seq_req_in.live, 2);
   endproperty
   a_fast: assert property (p_fast)
      else $error("shadow restore does not match save");

   property p_nested;
      s_save ##1 s_save ##1 s_restore |=> seq_ans_out.restore == $past(seq_req_in.live, 2);
   endproperty
   a_nested: assert property (p_nested)
      else $error("nested save did not overwrite shadow");

   property p_empty_read;
      bus_rd && level_reg == 5'h00 && hit(wb_adr_in, OFF_TOP_LOW) |=> wb_dat_out == 32'h0;
   endproperty
   a_empty_read: assert property (p_empty_read)
      else $error("level zero entry not zero");

   property p_top_write;
      bus_wr && hit(wb_adr_in, OFF_TOP_LOW) && level_reg != 5'h00
         && !seq_req_in.push && !seq_req_in.pop && !core_reset_in
         |=> top_value[7:0] == $past(wb_dat_in[7:0]);
   endproperty
   a_top_write: assert property (p_top_write)
      else $error("top entry write lost");

   property p_ack;
      wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bus answer timing wrong");

endmodule // return_stack_control

// *** hw/return_stack_pkg.sv ***
// Constants, register map and carrier types for the return stack controller.
// Assumes a single core clock; the sequencer drives requests on that clock.
//
// How it works
// - Stack level is a five-bit pointer ranging 0 through 31.
// - Push increments level then writes; pop reads entry then decrements.
// - Every reset clears the stack level to zero.
// - Software reads and overwrites the stack level field directly.
// - Full flag sets after 31 pushes without intervening pops.
// - Full and underflow flags clear only by software write or power-on reset.
// - Option set: 31st push stores value, sets full, resets; level zero.
// - Option clear: level stops at 31; further pushes change nothing stored.
// - Pop at level zero returns zero, sets underflow, level stays zero.
// - Option set: flag set then reset; option clear: flag set only.
// - Underflow without reset leaves all other registers untouched.
// - Explicit push increments level and stores current program counter.
// - Explicit pop discards top entry by decrementing level only.
// - Control register: full bit 7, underflow bit 6, zero bit 5, level 4:0.
// - One-level hidden shadow of status, working, bank select saved on interrupt.
// - Fast return from interrupt restores the shadow values.
// - Later high-priority save overwrites the shadow of a low-priority one.
// - Fast call saves the shadow; fast return restores it.
// - Store holds 31 entries of 21 bits; level zero has no storage.
// - Calls and interrupt entry push a value already pointing past the call.
// - Three byte windows read and write the entry at the current level.

package return_stack_pkg;
   localparam int         LEVEL_W       = 5;
   localparam int         ENTRY_W       = 21;
   localparam logic [4:0] LEVEL_MAX     = 5'h1f;
   localparam logic [4:0] LEVEL_LAST    = 5'h1e;
   localparam logic [7:0] OFF_CONTROL   = 8'h00;
   localparam logic [7:0] OFF_TOP_LOW   = 8'h04;
   localparam logic [7:0] OFF_TOP_HIGH  = 8'h08;
   localparam logic [7:0] OFF_TOP_UPPER = 8'h0c;
   localparam logic [7:0] OFF_CONFIG    = 8'h10;
   localparam int         FULL_BIT      = 7;
   localparam int         UNDER_BIT     = 6;
   localparam int         OPTION_BIT    = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic       OPTION_RESET  = 1'b1;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] working_register;
      logic [3:0] bank_select_register;
   } shadow_t;

   typedef struct packed {
      logic               push;
      logic               pop;
      logic [20:0]        push_value;
      logic               fast_save;
      logic               fast_restore;
      shadow_t            live;
   } seq_req_t;

   typedef struct packed {
      logic               pop_valid;
      logic [20:0]        pop_value;
      logic               restore_valid;
      shadow_t            restore;
   } seq_ans_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_t;
endpackage

// *** bench/seq_model.sv ***
// Sequencer model: issues push, pop, fast save and fast restore requests.
// Assumes requests are taken on the next rising edge of mclk_in.
`timescale 1ns/1ps

module seq_model
   import return_stack_pkg::*;
(
   input  wire logic     mclk_in,
   input  wire seq_ans_t seq_ans_in,
   input  wire logic     fault_reset_in,
   output seq_req_t      seq_req_out,
   output logic          core_reset_out
);
   seq_ans_t ans;
   logic     flt;

   initial begin
      seq_req_out    = '0;
      core_reset_out = 1'b0;
   end

   // One request for one cycle; answer captured once the next edge has landed
   task automatic op(input logic [3:0] kind, input logic [20:0] v, input shadow_t s);
      seq_req_t r;
      r = '0;
      {r.push, r.pop, r.fast_save, r.fast_restore} = kind;
      r.push_value = v;  // Caller hands the already advanced address
      r.live = s;
      @(posedge mclk_in);
      seq_req_out <= r;
      @(posedge mclk_in);
      // Released lines flip instead of holding, so stale data is never trusted
      r = '0;
      r.push_value = ~v;
      r.live = ~s;
      seq_req_out <= r;
      #1;
      ans = seq_ans_in;
      flt = fault_reset_in;
   endtask

   // Three requests on consecutive edges; the answer is taken after the last
   task automatic burst(input logic [3:0] k0, input shadow_t s0, input logic [3:0] k1,
                        input shadow_t s1, input logic [3:0] k2, input logic [20:0] v);
      seq_req_t r;
      r = '0;
      @(posedge mclk_in);
      {r.push, r.pop, r.fast_save, r.fast_restore} = k0;
      r.push_value = v;
      r.live = s0;
      seq_req_out <= r;
      @(posedge mclk_in);
      {r.push, r.pop, r.fast_save, r.fast_restore} = k1;
      r.live = s1;
      seq_req_out <= r;
      @(posedge mclk_in);
      {r.push, r.pop, r.fast_save, r.fast_restore} = k2;
      r.live = ~s1;
      seq_req_out <= r;
      @(posedge mclk_in);
      r = '0;
      r.push_value = ~v;
      seq_req_out <= r;
      #1;
      ans = seq_ans_in;
      flt = fault_reset_in;
   endtask

   task automatic core_reset();
      @(posedge mclk_in);
      core_reset_out <= 1'b1;
      @(posedge mclk_in);
      core_reset_out <= 1'b0;
   endtask
endmodule // seq_model

// *** bench/return_stack_control_tb.sv ***
// Self-checking bench for the return stack controller.
// Assumes seq_model drives the sequencer side; the bench is the Wishbone master.
`timescale 1ns/1ps

module return_stack_control_tb;
   import return_stack_pkg::*;
   localparam logic [3:0] PUSH = 4'h8;
   localparam logic [3:0] POP  = 4'h4;
   localparam logic [3:0] SAVE = 4'h2;
   localparam logic [3:0] REST = 4'h1;

   logic        mclk_in = 1'b0;
   logic        rst_n   = 1'b0;
   logic        core_rst;
   seq_req_t    req;
   seq_ans_t    ans;
   logic        flt;
   logic        wb_cyc  = 1'b0;
   logic        wb_stb  = 1'b0;
   logic        wb_we   = 1'b0;
   logic [7:0]  wb_adr  = 8'h00;
   logic [3:0]  wb_sel  = 4'h0;
   logic [31:0] wb_dat  = 32'h0;
   logic [31:0] wb_rdat;
   logic        wb_ack;
   int          err_count    = 0;
   int          total_checks = 0;
   int          cycles       = 0;

   always #5 mclk_in = ~mclk_in;

   return_stack_control u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n), .core_reset_in(core_rst),
      .seq_req_in(req), .seq_ans_out(ans), .fault_reset_out(flt), .wb_cyc_in(wb_cyc),
      .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
      .wb_dat_in(wb_dat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack));

   seq_model u_seq (.mclk_in(mclk_in), .seq_ans_in(ans), .fault_reset_in(flt),
      .seq_req_out(req), .core_reset_out(core_rst));

   // ----------------------------------------
   // Checking and bus helpers
   // ----------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // Classic cycle: hold until ack is sampled high, then release
   task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                      output logic [31:0] rd);
      @(posedge mclk_in);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= adr;
      wb_sel <= 4'hf;
      wb_dat <= {24'h0, wd};
      // Only the bench timeout ends a wait for the answer
      do begin
         @(posedge mclk_in);
      end while (wb_ack !== 1'b1);
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_dat <= ~{24'h0, wd};
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      logic [31:0] x;
      bus(1'b1, adr, d, x);
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, adr, 8'h00, x);
      check(x, exp);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_reset();
      rd_chk(OFF_CONTROL, 32'h00);
      rd_chk(OFF_CONFIG, 32'h01);
      rd_chk(OFF_TOP_LOW, 32'h00);
      $display("test_reset done");
   endtask

   task automatic test_push_pop();
      u_seq.op(PUSH, 21'h012345, '0);
      u_seq.op(PUSH, 21'h1abcde, '0);
      rd_chk(OFF_CONTROL, 32'h02);
      rd_chk(OFF_TOP_LOW, 32'hde);
      rd_chk(OFF_TOP_HIGH, 32'hbc);
      rd_chk(OFF_TOP_UPPER, 32'h1a);
      u_seq.op(POP, '0, '0);
      check(32'({u_seq.ans.pop_valid, u_seq.ans.pop_value}), 32'h3abcde);
      wr(OFF_TOP_LOW, 8'h77);
      u_seq.op(POP, '0, '0);
      check(32'({u_seq.ans.pop_valid, u_seq.ans.pop_value}), 32'h212377);
      // Option is set out of reset, so the underflow also requests a reset
      u_seq.op(POP, '0, '0);
      check(32'({u_seq.ans.pop_valid, u_seq.ans.pop_value, u_seq.flt}), 32'h400001);
      rd_chk(OFF_CONTROL, 32'h40);
      wr(OFF_CONTROL, 8'hc0);
      rd_chk(OFF_CONTROL, 32'h40);
      wr(OFF_CONTROL, 8'h00);
      rd_chk(OFF_CONTROL, 32'h00);
      wr(OFF_CONTROL, 8'hc3);
      rd_chk(OFF_CONTROL, 32'h03);
      wr(OFF_CONTROL, 8'h00);
      wr(OFF_CONFIG, 8'h00);
      u_seq.op(POP, '0, '0);
      check(32'({u_seq.ans.pop_value, u_seq.flt}), 32'h0);
      rd_chk(OFF_CONTROL, 32'h40);
      rd_chk(OFF_CONFIG, 32'h00);
      $display("test_push_pop done");
   endtask

   task automatic test_full_hold();
      wr(OFF_CONTROL, 8'h00);
      for (int i = 1; i <= 30; i++) begin
         u_seq.op(PUSH, 21'(i), '0);
      end
      rd_chk(OFF_CONTROL, 32'h1e);
      u_seq.op(PUSH, 21'h00001f, '0);
      check({28'h0, 3'b000, u_seq.flt}, 32'h0);
      rd_chk(OFF_CONTROL, 32'h9f);
      u_seq.op(PUSH, 21'h1fffff, '0);
      rd_chk(OFF_CONTROL, 32'h9f);
      rd_chk(OFF_TOP_LOW, 32'h1f);
      $display("test_full_hold done");
   endtask

   task automatic test_full_reset();
      wr(OFF_CONFIG, 8'h01);
      wr(OFF_CONTROL, 8'h1e);
      u_seq.op(PUSH, 21'h000102, '0);
      check({31'h0, u_seq.flt}, 32'h1);
      rd_chk(OFF_CONTROL, 32'h80);
      wr(OFF_CONTROL, 8'h1f);
      rd_chk(OFF_TOP_LOW, 32'h02);
      wr(OFF_CONTROL, 8'h05);
      u_seq.core_reset();
      rd_chk(OFF_CONTROL, 32'h00);
      // Only a power-on reset clears a flag besides software
      wr(OFF_CONFIG, 8'h00);
      u_seq.op(POP, '0, '0);
      rd_chk(OFF_CONTROL, 32'h40);
      @(posedge mclk_in);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk_in);
      rst_n <= 1'b1;
      rd_chk(OFF_CONTROL, 32'h00);
      rd_chk(OFF_CONFIG, 32'h01);
      $display("test_full_reset done");
   endtask

   task automatic test_fast();
      u_seq.op(SAVE, '0, {8'h11, 8'h22, 4'h3});
      u_seq.op(SAVE, '0, {8'h44, 8'h55, 4'h6});
      u_seq.op(REST, '0, '0);
      check(32'({u_seq.ans.restore_valid, u_seq.ans.restore}), 32'h144556);
      u_seq.op(SAVE, '0, {8'ha5, 8'h5a, 4'hc});
      u_seq.op(REST, '0, '0);
      check(32'({u_seq.ans.restore_valid, u_seq.ans.restore}), 32'h1a55ac);
      // Back to back: two saves then a restore, and a push popped at once
      u_seq.burst(SAVE, {8'h12, 8'h34, 4'h5}, SAVE, {8'h67, 8'h89, 4'ha}, REST, '0);
      check(32'({u_seq.ans.restore_valid, u_seq.ans.restore}), 32'h16789a);
      u_seq.burst(4'h0, '0, PUSH, '0, POP, 21'h0abcde);
      check(32'({u_seq.ans.pop_valid, u_seq.ans.pop_value}), 32'h2abcde);
      wr(8'h14, 8'hff);
      rd_chk(8'h14, 32'h0);
      $display("test_fast done");
   endtask

   always @(posedge mclk_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         summarize();
      end
   end

   initial begin
      repeat (2) @(posedge mclk_in);
      rst_n <= 1'b1;
      test_reset();
      test_push_pop();
      test_full_hold();
      test_full_reset();
      test_fast();
      summarize();
   end
endmodule // return_stack_control_tb
